// ==== rtl/crxb0_ctrl.v ====
`include "crxb0_defines.vh"

// Overview of operation
// - Full flag bit 7 sets when a message is stored; clear means buffer free.
// - Mode 11 accepts everything including errors; mode 00 all valid messages.
// - Mode 10 accepts valid extended only; mode 01 valid standard only.
// - Bit 3 reads one when stored message is a remote request.
// - Double-buffer enable bit 2 spills overflow into a non-full buffer 1; else no spill.
// - Bit 0 records which acceptance filter admitted the stored message.
module crxb0_ctrl
(
    input  wire       SYS_CLK_I,
    input  wire       SYS_RST_I,
    input  wire [3:0] ADDR_I,
    input  wire [7:0] WDATA_I,
    input  wire       WR_I,
    input  wire       RD_I,
    output reg  [7:0] RDATA_O,
    input  wire       MSG_VALID_I,
    input  wire       MSG_ERROR_I,
    input  wire       MSG_EXT_I,
    input  wire       MSG_RTR_I,
    input  wire       MSG_FILTER_I,
    output wire       STORE_B0_O,
    output wire       STORE_B1_O,
    input  wire       B1_FULL_I,
    output wire       IRQ_O
);

    ////////////////////////////////////////////////////////////////////////////
    reg  [1:0] mode_ff;
    reg        dben_ff;
    reg        rtr_ff;
    reg        filhit_ff;
    reg  [2:0] mask_ff;
    wire       full;
    wire [2:0] evt_q;
    reg        mode_ok;
    wire       accept;
    wire       lost;
    wire       wr_ctrl;
    wire       wr_stat;
    wire       clr_full;
    wire [2:0] evt_set;
    wire [2:0] evt_clr;
    wire [7:0] ctrl_view;

    assign wr_ctrl = WR_I & (ADDR_I == `CRXB0_ADDR_CTRL);
    assign wr_stat = WR_I & (ADDR_I == `CRXB0_ADDR_STATUS);

    ////////////////////////////////////////////////////////////////////////////
    // Acceptance by receive mode.
    always @*
    begin
        mode_ok = 1'b0;
        case (mode_ff)
            `CRXB0_MODE_ALL_ANY:   mode_ok = 1'b1;
            `CRXB0_MODE_ALL_VALID: mode_ok = ~MSG_ERROR_I;
            `CRXB0_MODE_EXT_ONLY:  mode_ok = ~MSG_ERROR_I & MSG_EXT_I;
            `CRXB0_MODE_STD_ONLY:  mode_ok = ~MSG_ERROR_I & ~MSG_EXT_I;
            default:               mode_ok = 1'b0;
        endcase
    end

    assign accept     = MSG_VALID_I & mode_ok;
    assign STORE_B0_O = accept & ~full;
    assign STORE_B1_O = accept & full & dben_ff & ~B1_FULL_I;
    assign lost       = accept & full & ~STORE_B1_O;

    ////////////////////////////////////////////////////////////////////////////
    // Full flag: hardware sets, software writes one to clear.
    assign clr_full = wr_ctrl & WDATA_I[`CRXB0_BIT_FULL];

    crxb0_sticky u_full
    (
        .SYS_CLK_I (SYS_CLK_I),
        .SYS_RST_I (SYS_RST_I),
        .set_i     (STORE_B0_O),
        .clr_i     (clr_full),
        .q_o       (full)
    );

    assign evt_set = {lost, STORE_B1_O, STORE_B0_O};
    assign evt_clr = {3{wr_stat}} & WDATA_I[2:0];

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_evt
            crxb0_sticky u_evt
            (
                .SYS_CLK_I (SYS_CLK_I),
                .SYS_RST_I (SYS_RST_I),
                .set_i     (evt_set[gi]),
                .clr_i     (evt_clr[gi]),
                .q_o       (evt_q[gi])
            );
        end
    endgenerate

    assign IRQ_O = |(evt_q & mask_ff);

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            mode_ff   <= `CRXB0_RST_MODE;
            dben_ff   <= `CRXB0_RST_FLAG;
            rtr_ff    <= `CRXB0_RST_FLAG;
            filhit_ff <= `CRXB0_RST_FLAG;
            mask_ff   <= `CRXB0_RST_EVT;
        end
        else
        begin
            if (wr_ctrl)
            begin
                mode_ff <= WDATA_I[`CRXB0_BIT_MODE_HI:`CRXB0_BIT_MODE_LO];
                dben_ff <= WDATA_I[`CRXB0_BIT_DBEN];
            end
            if (WR_I & (ADDR_I == `CRXB0_ADDR_MASK))
                mask_ff <= WDATA_I[2:0];
            if (STORE_B0_O)
            begin
                rtr_ff    <= MSG_RTR_I;
                filhit_ff <= MSG_FILTER_I;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit 4 reads zero; the offset bit is a copy of the enable.
    assign ctrl_view = {full, mode_ff, 1'b0, rtr_ff, dben_ff,
                        dben_ff, filhit_ff};

    always @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
            RDATA_O <= `CRXB0_RST_RDATA;
        else if (RD_I)
        begin
            case (ADDR_I)
                `CRXB0_ADDR_CTRL:   RDATA_O <= ctrl_view;
                `CRXB0_ADDR_STATUS: RDATA_O <= {5'h00, evt_q};
                `CRXB0_ADDR_MASK:   RDATA_O <= {5'h00, mask_ff};
                default:            RDATA_O <= 8'h00;
            endcase
        end
        else
            RDATA_O <= 8'h00;
    end

endmodule // crxb0_ctrl

// ==== rtl/crxb0_defines.vh ====
`ifndef CRXB0_DEFINES_VH
`define CRXB0_DEFINES_VH

`define CRXB0_ADDR_CTRL      4'h0
`define CRXB0_ADDR_STATUS    4'h1
`define CRXB0_ADDR_MASK      4'h2

`define CRXB0_BIT_FULL       7
`define CRXB0_BIT_MODE_HI    6
`define CRXB0_BIT_MODE_LO    5
`define CRXB0_BIT_RTR        3
`define CRXB0_BIT_DBEN       2
`define CRXB0_BIT_JUMP_OFS   1
`define CRXB0_BIT_HIT        0

`define CRXB0_MODE_ALL_VALID 2'h0
`define CRXB0_MODE_STD_ONLY  2'h1
`define CRXB0_MODE_EXT_ONLY  2'h2
`define CRXB0_MODE_ALL_ANY   2'h3

`define CRXB0_EVT_STORE      0
`define CRXB0_EVT_SPILL      1
`define CRXB0_EVT_LOST       2

`define CRXB0_RST_CTRL       8'h00
`define CRXB0_RST_EVT        3'h0
`define CRXB0_RST_MODE       2'h0
`define CRXB0_RST_FLAG       1'h0
`define CRXB0_RST_RDATA      8'h00

`endif

// ==== rtl/crxb0_sticky.v ====
`include "crxb0_defines.vh"

module crxb0_sticky
(
    input  wire SYS_CLK_I,
    input  wire SYS_RST_I,
    input  wire set_i,
    input  wire clr_i,
    output wire q_o
);

    reg  flag_ff;
    wire nxt_flag;

    // A set arriving together with a clear wins.
    assign nxt_flag = set_i | (flag_ff & ~clr_i);

    always @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
            flag_ff <= `CRXB0_RST_FLAG;
        else
            flag_ff <= nxt_flag;
    end

    assign q_o = flag_ff;

endmodule // crxb0_sticky

// ==== tb/crxb0_msg_model.sv ====
module crxb0_msg_model
(
    input  wire logic clk,
    output logic      vld = 0,
    output logic [3:0] att = 0
);
    timeunit 1ns;
    timeprecision 1ns;
    task send(input logic [3:0] a);
        @(posedge clk) vld <= 1;
        att <= a;
        #50;
    endtask
    // Released attribute lines show inverted garbage.
    task stop;
        @(posedge clk) vld <= 0;
        att <= ~att;
    endtask
endmodule // crxb0_msg_model

// ==== tb/crxb0_ctrl_checker.sv ====
module crxb0_ctrl_checker
(
    input wire logic       SYS_CLK_I,
    input wire logic       SYS_RST_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic       MSG_VALID_I,
    input wire logic       MSG_ERROR_I,
    input wire logic       MSG_EXT_I,
    input wire logic       MSG_RTR_I,
    input wire logic       MSG_FILTER_I,
    input wire logic       STORE_B0_O,
    input wire logic       STORE_B1_O,
    input wire logic       B1_FULL_I,
    input wire logic       IRQ_O
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    logic [1:0] mode_ff;
    always @(posedge SYS_CLK_I)
        if (SYS_RST_I) mode_ff <= 2'h0;
        else if (WR_I && ADDR_I == 4'h0) mode_ff <= WDATA_I[6:5];
    sequence ctrl_rd;
        RD_I && ADDR_I == 4'h0;
    endsequence
    a_store_has_msg: assert property (STORE_B0_O || STORE_B1_O |-> MSG_VALID_I) else $error("bad store");
    a_mode_filter: assert property (STORE_B0_O || STORE_B1_O |-> mode_ff == 2'h3 ||
        !MSG_ERROR_I && (mode_ff == 2'h0 || mode_ff[1] == MSG_EXT_I)) else $error("mode filter");
    a_one_target: assert property (!(STORE_B0_O && STORE_B1_O)) else $error("two targets");
    a_spill_room: assert property (STORE_B1_O |-> !B1_FULL_I) else $error("spill full");
    a_offset_copy: assert property (ctrl_rd |=> RDATA_O[1] == RDATA_O[2] && !RDATA_O[4]) else $error("copy");
    a_full_after: assert property (STORE_B0_O ##1 !WR_I ##1 ctrl_rd |=> RDATA_O[7] &&
        RDATA_O[3] == $past(MSG_RTR_I, 3) && RDATA_O[0] == $past(MSG_FILTER_I, 3)) else $error("flags");
    a_rdata_idle: assert property (!RD_I |=> RDATA_O == 8'h00) else $error("idle data");
    a_full_blocks: assert property (STORE_B0_O |=> !STORE_B0_O) else $error("store while full");
    a_irq_cause: assert property ($rose(IRQ_O) |-> $past(MSG_VALID_I || WR_I)) else $error("irq cause");
endmodule // crxb0_ctrl_checker
bind crxb0_ctrl crxb0_ctrl_checker u_chk
(
    .SYS_CLK_I    (SYS_CLK_I),
    .SYS_RST_I    (SYS_RST_I),
    .ADDR_I       (ADDR_I),
    .WDATA_I      (WDATA_I),
    .WR_I         (WR_I),
    .RD_I         (RD_I),
    .RDATA_O      (RDATA_O),
    .MSG_VALID_I  (MSG_VALID_I),
    .MSG_ERROR_I  (MSG_ERROR_I),
    .MSG_EXT_I    (MSG_EXT_I),
    .MSG_RTR_I    (MSG_RTR_I),
    .MSG_FILTER_I (MSG_FILTER_I),
    .STORE_B0_O   (STORE_B0_O),
    .STORE_B1_O   (STORE_B1_O),
    .B1_FULL_I    (B1_FULL_I),
    .IRQ_O        (IRQ_O)
);

// ==== tb/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, wr = 0, rd = 0, b1f = 0;
    logic [3:0] adr = 0;
    logic [7:0] wd = 0;
    wire [7:0] rdat;
    wire [3:0] at;
    wire vld, s0, s1, irq;
    int fails = 0, checks = 0;
    initial forever #50 clk = ~clk;
    crxb0_ctrl u_crxb0_ctrl(.SYS_CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(adr), .WDATA_I(wd), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdat), .MSG_VALID_I(vld), .MSG_ERROR_I(at[3]), .MSG_EXT_I(at[2]), .MSG_RTR_I(at[1]),
        .MSG_FILTER_I(at[0]), .STORE_B0_O(s0), .STORE_B1_O(s1), .B1_FULL_I(b1f), .IRQ_O(irq));
    crxb0_msg_model u_m(.clk(clk), .vld(vld), .att(at));
    task cmp(input logic [7:0] g, e);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wrr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) wr <= 1;
        adr <= a;
        wd <= d;
        @(posedge clk) wr <= 0;
    endtask
    task rdc(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk) rd <= 1;
        adr <= a;
        @(posedge clk) rd <= 0;
        #50 cmp(rdat, e);
    endtask
    task t_regs;
        rdc(4'h0, 8'h00);
        rdc(4'h9, 8'h00);
        wrr(4'h0, 8'hff);
        rdc(4'h0, 8'h66);
    endtask
    task t_modes;
        for (int i = 0; i < 16; i++)
        begin
            wrr(4'h0, {1'b1, i[3:2], 5'h00});
            u_m.send({i[1:0], 2'h0});
            cmp(s0, i[3:2] == 3 || !i[1] && (i[3:2] == 0 || i[3] == i[0]));
            u_m.stop;
        end
    endtask
    task t_spill;
        wrr(4'h1, 8'h07);
        wrr(4'h0, 8'h80);
        u_m.send(4'h3);
        cmp(s0, 8'h01);
        u_m.stop;
        rdc(4'h0, 8'h89);
        u_m.send(4'h0);
        cmp(s1, 8'h00);
        u_m.stop;
        wrr(4'h0, 8'h04);
        u_m.send(4'h0);
        cmp(s1, 8'h01);
        u_m.stop;
        @(posedge clk) b1f <= 1;
        u_m.send(4'h0);
        cmp(s1, 8'h00);
        cmp(s0, 8'h00);
        u_m.stop;
        b1f <= 0;
        rdc(4'h0, 8'h8f);
        rdc(4'h1, 8'h07);
        wrr(4'h2, 8'h02);
        #50 cmp(irq, 8'h01);
        wrr(4'h1, 8'h02);
        #50 cmp(irq, 8'h00);
        wrr(4'h0, 8'h84);
        rdc(4'h0, 8'h0f);
    endtask
    task t_reset;
        wrr(4'h2, 8'h07);
        #50 cmp(irq, 8'h01);
        @(posedge clk) rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        rdc(4'h2, 8'h00);
        rdc(4'h1, 8'h00);
        rdc(4'h0, 8'h00);
        cmp(irq, 8'h00);
    endtask
    task give_verdict;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #100000 fails++;
        give_verdict;
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 0;
        t_regs;
        t_modes;
        t_spill;
        t_reset;
        give_verdict;
    end
endmodule // tb
